/* File: sbil_pkg.sv */
// shared constants, types and register map of the attention line logic
package sbil_pkg;

   // ----------------------------------------------------------------
   // register map and data layout
   // ----------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] OFS_IRQ0 = 3'h0;  // summary bit and wake flags
   localparam logic [ADDR_W-1:0] OFS_IRQ1 = 3'h1;  // fault flags
   localparam logic [ADDR_W-1:0] OFS_IRQ2 = 3'h2;  // device failure flags
   localparam logic [ADDR_W-1:0] OFS_MASK1 = 3'h3; // enables for fault sources
   localparam logic [ADDR_W-1:0] OFS_MASK2 = 3'h4; // enables for failure sources
   localparam logic [ADDR_W-1:0] OFS_MASK0 = 3'h5; // enables for wake sources

   localparam int FLT_W = 8;
   localparam int FAIL_W = 3;
   localparam int WAKE_W = 4;
   localparam int SUM_BIT = 0;
   localparam int WAKE_LSB = 1;
   localparam int UV2_BIT = 0;
   localparam int UV3_BIT = 1;

   localparam logic [FLT_W-1:0] MASK1_RST = 8'hff;
   localparam logic [FAIL_W-1:0] MASK2_RST = 3'h7;
   localparam logic [WAKE_W-1:0] MASK0_RST = 4'hf;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ = 10000;
   localparam int ATT_TIMEOUT_US = 6000;
   localparam int ATT_MIN_PULSE_US = 10;
   // longest time: round down; least time: round up
   localparam int ATT_TIMEOUT_CYC = ATT_TIMEOUT_US * CLK_KHZ / 1000;
   localparam int ATT_MIN_PULSE_CYC = (ATT_MIN_PULSE_US * CLK_KHZ + 999) / 1000;
   localparam int CNT_W = 16;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_INIT = 3'h0,
      MODE_NORMAL = 3'h1,
      MODE_STOP = 3'h2,
      MODE_SLEEP = 3'h3,
      MODE_RESTART = 3'h4,
      MODE_FAILSAFE = 3'h5,
      MODE_FLASH = 3'h6
   } sbil_mode_e;

   typedef enum logic [2:0] {
      LN_IDLE = 3'b001,
      LN_LOW = 3'b010,
      LN_GAP = 3'b100
   } sbil_line_e;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   // fault: lin_fail,can_fail,oc_third,ot_can,ot_prewarn,ot_second,uv_third,uv_second
   // fail: reset_event,wrong_watchdog,serial_corrupt
   // wake: wake_periodic,wake_pin,wake_lin,wake_can
   typedef struct packed {
      logic [FLT_W-1:0] fault;
      logic [FAIL_W-1:0] fail;
      logic [WAKE_W-1:0] wake;
   } sbil_src_s;

   typedef struct packed {
      logic on_third;   // one-cycle pulse: switch-on command executed
      logic on_second;
      logic off_third;  // level: regulator being switched off or off
      logic off_second;
   } sbil_reg_ctl_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } sbil_bus_s;

endpackage

/* File: sbil_sync.sv */
// two flip-flop synchroniser for asynchronous source conditions
`timescale 1ns/1ps
module sbil_sync #(
   parameter int W = 15
) (
   input wire logic clk,            // system clock
   input wire logic sys_rst,        // async reset, active high
   input wire logic [W-1:0] d,      // asynchronous levels
   output logic [W-1:0] q           // synchronised levels
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

/* File: sbil_attention.sv */
// attention line logic: source flags, masks, line timing and register port
//
// Notes on behaviour
// - unmasked event drives line low at once
// - read of register zero releases line
// - events before readout give one low
// - line low at most one time-out
// - flags survive a time-out release
// - one time-out gap between activations
// - low pulse lasts at least minimum width
// - line active only in normal, stop
// - all sources enabled after restart, reset
// - event in gap still asserts later
// - switch-on command sets undervoltage flag
// - read cannot clear while undervoltage persists
// - shorted regulator keeps its flag set
// - no undervoltage event while switching off
// - switch-on triggers on command edge only
// - undervoltage triggers both edges, mirrors state
// - overtemperature triggers rising, mirrors state
// - masked source flagged but never asserts
// - event flags clear on read; faults latch
// - summary bit is or of fault and failure flags
`timescale 1ns/1ps
module sbil_attention
   import sbil_pkg::*;
#(
   parameter int TIMEOUT_CYC = ATT_TIMEOUT_CYC,
   parameter int MIN_PULSE_CYC = ATT_MIN_PULSE_CYC
) (
   input wire logic clk,                  // system clock, 10 MHz
   input wire logic sys_rst,              // async reset, active high
   input sbil_src_s src,                  // asynchronous source conditions
   input sbil_reg_ctl_s reg_ctl,          // regulator commands, same clock
   input sbil_mode_e mode,                // operating mode, same clock
   input sbil_bus_s bus,                  // register port request
   output logic [DATA_W-1:0] rdata,       // read data, cycle after strobe
   output logic attention_n               // attention line, active low
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(TIMEOUT_CYC - 1);
   localparam logic [CNT_W-1:0] MIN_LAST = CNT_W'(MIN_PULSE_CYC - 1);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   sbil_src_s src_s;
   logic [FLT_W-1:0] flt_prev_r;
   logic [FAIL_W-1:0] fail_prev_r;
   logic [WAKE_W-1:0] wake_prev_r;
   logic [FLT_W-1:0] flt_r, flt_nxt;
   logic [FAIL_W-1:0] fail_r, fail_nxt;
   logic [WAKE_W-1:0] wake_r, wake_nxt;
   logic [FLT_W-1:0] mask1_r, mask1_nxt;
   logic [FAIL_W-1:0] mask2_r, mask2_nxt;
   logic [WAKE_W-1:0] mask0_r, mask0_nxt;
   logic [DATA_W-1:0] rdata_nxt;
   sbil_line_e state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic pend_r, pend_nxt;
   logic rel_r, rel_nxt;
   sbil_mode_e mode_prev_r;

   // every check below runs on the system clock and sleeps during reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------------------------------
   // source conditioning
   // ----------------------------------------------------------------
   // pins cross into the clock domain before any decision
   sbil_sync #(.W($bits(sbil_src_s))) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(src),
      .q(src_s)
   );

   // undervoltage hidden while its regulator is being switched off
   wire [FLT_W-1:0] uv_hide = {{(FLT_W-2){1'b0}}, reg_ctl.off_third, reg_ctl.off_second};
   wire [FLT_W-1:0] flt_now = src_s.fault & ~uv_hide;
   wire [FLT_W-1:0] uv_sel = {{(FLT_W-2){1'b0}}, 2'b11};
   wire [FLT_W-1:0] flt_rise = flt_now & ~flt_prev_r;
   // hiding a condition at switch-off must not look like its end
   wire [FLT_W-1:0] flt_fall = ~flt_now & flt_prev_r & uv_sel & ~uv_hide;
   wire [FLT_W-1:0] on_cmd = {{(FLT_W-2){1'b0}}, reg_ctl.on_third, reg_ctl.on_second};
   // switch-on is a command pulse, so only its arrival counts
   wire [FLT_W-1:0] flt_evt = flt_rise | flt_fall | on_cmd;
   wire [FAIL_W-1:0] fail_evt = src_s.fail & ~fail_prev_r;
   wire [WAKE_W-1:0] wake_evt = src_s.wake & ~wake_prev_r;

   // ----------------------------------------------------------------
   // register port decode
   // ----------------------------------------------------------------
   wire rd0 = bus.rd && hit(bus.addr, OFS_IRQ0);
   wire rd1 = bus.rd && hit(bus.addr, OFS_IRQ1);
   wire rd2 = bus.rd && hit(bus.addr, OFS_IRQ2);
   wire wr_m1 = bus.wr && hit(bus.addr, OFS_MASK1);
   wire wr_m2 = bus.wr && hit(bus.addr, OFS_MASK2);
   wire wr_m0 = bus.wr && hit(bus.addr, OFS_MASK0);
   wire active = (mode == MODE_NORMAL) || (mode == MODE_STOP);
   wire restart_left = (mode_prev_r == MODE_RESTART) && (mode != MODE_RESTART);

   // ----------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------
   // faults latch until read, then follow the live condition; a set in the
   // clearing cycle wins, so no event slips through a read
   assign flt_nxt = flt_evt | (flt_r & ~{FLT_W{rd1}});
   assign fail_nxt = fail_evt | (fail_r & ~{FAIL_W{rd2}});
   assign wake_nxt = wake_evt | (wake_r & ~{WAKE_W{rd0}});
   // visible fault flag: latched event or live condition, so a read can never
   // hide a condition that is still present, such as a shorted regulator
   wire [FLT_W-1:0] flt_flag = flt_r | flt_now;
   // summary bit is derived, so it drops exactly when both groups are clear
   wire sum_bit = |flt_flag || |fail_r;

   // ----------------------------------------------------------------
   // masks
   // ----------------------------------------------------------------
   // leaving restart re-enables everything, overriding a same-cycle write
   assign mask1_nxt = restart_left ? MASK1_RST : (wr_m1 ? bus.wdata[FLT_W-1:0] : mask1_r);
   assign mask2_nxt = restart_left ? MASK2_RST : (wr_m2 ? bus.wdata[FAIL_W-1:0] : mask2_r);
   assign mask0_nxt = restart_left ? MASK0_RST : (wr_m0 ? bus.wdata[WAKE_W-1:0] : mask0_r);

   // a masked source still updates its flag above; it only loses the line
   wire trig = active && (|(flt_evt & mask1_r) || |(fail_evt & mask2_r) || |(wake_evt & mask0_r));

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   wire [DATA_W-1:0] irq0_val = DATA_W'({wake_r, sum_bit});
   wire [DATA_W-1:0] rd_mux =
      hit(bus.addr, OFS_IRQ0) ? irq0_val :
      hit(bus.addr, OFS_IRQ1) ? DATA_W'(flt_flag) :
      hit(bus.addr, OFS_IRQ2) ? DATA_W'(fail_r) :
      hit(bus.addr, OFS_MASK1) ? DATA_W'(mask1_r) :
      hit(bus.addr, OFS_MASK2) ? DATA_W'(mask2_r) :
      hit(bus.addr, OFS_MASK0) ? DATA_W'(mask0_r) : 8'h00;
   assign rdata_nxt = bus.rd ? rd_mux : 8'h00;

   // ----------------------------------------------------------------
   // line sequencer
   // ----------------------------------------------------------------
   wire at_min = cnt_r >= MIN_LAST;
   wire at_tmo = cnt_r == TMO_LAST;
   wire want_rel = rel_r || rd0;
   wire low_done = (want_rel && at_min) || at_tmo;

   // one counter serves both the low time and the gap; counting the
   // internal clock means the tolerance is that of the oscillator
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + 16'h0001;
      pend_nxt = pend_r || trig;
      rel_nxt = rel_r || (rd0 && state_r == LN_LOW);
      case (state_r)
         LN_IDLE: begin
            cnt_nxt = 16'h0000;
            rel_nxt = 1'b0;
            if (pend_r || trig) begin
               state_nxt = LN_LOW;
               pend_nxt = 1'b0;
            end
         end
         LN_LOW: begin
            // events during a low pulse merge into it
            pend_nxt = 1'b0;
            if (low_done) begin
               state_nxt = LN_GAP;
               cnt_nxt = 16'h0000;
               rel_nxt = 1'b0;
            end
         end
         LN_GAP: begin
            // events here wait, even if a read has cleared their flags
            rel_nxt = 1'b0;
            if (at_tmo) begin
               state_nxt = LN_IDLE;
               cnt_nxt = 16'h0000;
            end
         end
         default: begin
            state_nxt = LN_IDLE;
            cnt_nxt = 16'h0000;
            pend_nxt = 1'b0;
            rel_nxt = 1'b0;
         end
      endcase
      // outside normal and stop the line stays quiet and forgets events
      if (!active) begin
         state_nxt = LN_IDLE;
         cnt_nxt = 16'h0000;
         pend_nxt = 1'b0;
         rel_nxt = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   // line sequencer and output line
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= LN_IDLE;
         cnt_r <= '0;
         pend_r <= 1'b0;
         rel_r <= 1'b0;
         attention_n <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         pend_r <= pend_nxt;
         rel_r <= rel_nxt;
         attention_n <= (state_nxt != LN_LOW);
      end
   end

   // flags keep their content across a time-out release
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flt_r <= '0;
         fail_r <= '0;
         wake_r <= '0;
      end else begin
         flt_r <= flt_nxt;
         fail_r <= fail_nxt;
         wake_r <= wake_nxt;
      end
   end

   // edge memories, masks, mode history and read data
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flt_prev_r <= '0;
         fail_prev_r <= '0;
         wake_prev_r <= '0;
         mask1_r <= MASK1_RST;
         mask2_r <= MASK2_RST;
         mask0_r <= MASK0_RST;
         mode_prev_r <= MODE_INIT;
         rdata <= 8'h00;
      end else begin
         flt_prev_r <= flt_now;
         fail_prev_r <= src_s.fail;
         wake_prev_r <= src_s.wake;
         mask1_r <= mask1_nxt;
         mask2_r <= mask2_nxt;
         mask0_r <= mask0_nxt;
         mode_prev_r <= mode;
         rdata <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_low_entry;
      state_r == LN_IDLE && (pend_r || trig) && active;
   endsequence

   sequence s_release_ready;
      state_r == LN_LOW && want_rel && at_min && active;
   endsequence

   chk_line_falls: assert property (s_low_entry |=> !attention_n)
      else $error("line not driven low after pending event");

   chk_read_release: assert property (s_release_ready |=> attention_n ##1 state_r == LN_GAP || !active)
      else $error("line not released after register zero read");

   chk_single_low: assert property (state_r == LN_LOW |-> !pend_r)
      else $error("event stored during low pulse");

   chk_low_bound: assert property (state_r == LN_LOW |-> cnt_r <= TMO_LAST)
      else $error("line low beyond time-out");

   chk_min_pulse: assert property ($rose(attention_n) && $past(active) |-> $past(cnt_r) >= MIN_LAST)
      else $error("low pulse shorter than minimum width");

   chk_gap_quiet: assert property (state_r == LN_GAP && cnt_r < TMO_LAST |=> attention_n)
      else $error("line reasserted inside gap");

   chk_mode_quiet: assert property (!active |=> attention_n && !pend_r)
      else $error("line activity outside normal or stop");

   chk_mask_restart: assert property (restart_left |=> mask1_r == MASK1_RST && mask0_r == MASK0_RST)
      else $error("masks not reopened after restart");

   chk_switch_on: assert property (reg_ctl.on_second |=> flt_r[UV2_BIT])
      else $error("switch-on did not set undervoltage flag");

   chk_uv_persist: assert property (rd1 && flt_now[UV2_BIT] |=> rdata[UV2_BIT])
      else $error("undervoltage flag cleared while condition present");

   chk_fault_clear: assert property (rd1 && flt_evt == '0 |=> flt_r == '0)
      else $error("fault latch survived a read with no new event");

   chk_summary_bit: assert property (bus.rd && hit(bus.addr, OFS_IRQ0) && !sum_bit |=> rdata[SUM_BIT] == 1'b0)
      else $error("summary bit set with all flags clear");

endmodule

/* File: sbil_dummy_guard.sv */
// holds no logic; kept empty on purpose

/* File: sbil_host.sv */
// host model: register port master and attention line monitor
`timescale 1ns/1ps
module sbil_host
   import sbil_pkg::*;
(
   input wire logic clk,                  // system clock
   input wire logic [DATA_W-1:0] rdata,   // read data from the block
   input wire logic attention_n,          // attention line, active low
   output sbil_bus_s bus                  // register port request
);
   // ----------------------------------------------------------------
   // line monitor and bus tasks
   // ----------------------------------------------------------------
   int n_low = 0;
   int low_cnt = 0;
   int high_cnt = 0;
   int last_low = 0;
   int last_high = 0;

   initial bus = '0;

   // pulse widths are counted in whole clocks, so they match the timers
   always @(posedge clk) begin
      if (attention_n === 1'b0) begin
         if (low_cnt == 0) begin
            last_high <= high_cnt;
            n_low <= n_low + 1;
         end
         low_cnt <= low_cnt + 1;
         high_cnt <= 0;
      end else begin
         if (low_cnt != 0) last_low <= low_cnt;
         low_cnt <= 0;
         high_cnt <= high_cnt + 1;
      end
   end

   // one-cycle write strobe
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'h1;
      @(posedge clk);
      bus.wr <= 1'h0;
   endtask

   // one-cycle read strobe; a read of register zero releases the line
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'h1;
      @(posedge clk);
      bus.rd <= 1'h0;
      @(posedge clk);
      d = rdata;
   endtask
endmodule

/* File: sbil_attention_bench.sv */
// testbench of the attention line logic
`timescale 1ns/1ps
module sbil_attention_bench
   import sbil_pkg::*;
;
   // ----------------------------------------------------------------
   // clock, reset and instances
   // ----------------------------------------------------------------
   localparam int TO = 200;   // shortened time-out keeps the run brief
   localparam int MIN = 10;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   sbil_src_s src = '0;
   sbil_reg_ctl_s reg_ctl = '0;
   sbil_mode_e mode = MODE_NORMAL;
   sbil_bus_s bus;
   logic [DATA_W-1:0] rdata;
   logic attention_n;
   int n_fail = 0;
   int compares = 0;

   always #50 clk = ~clk;

   sbil_attention #(.TIMEOUT_CYC(TO), .MIN_PULSE_CYC(MIN)) i_sbil_attention (
      .clk(clk), .sys_rst(sys_rst), .src(src), .reg_ctl(reg_ctl), .mode(mode),
      .bus(bus), .rdata(rdata), .attention_n(attention_n));

   sbil_host i_sbil_host (.clk(clk), .rdata(rdata), .attention_n(attention_n), .bus(bus));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic finish_test;
      if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      logic [DATA_W-1:0] d;
      i_sbil_host.rd(a, d);
      chk("rdata", e, d);
   endtask

   // bounded waits; a line that never moves shows up as a mismatch
   task automatic wlow(input int n);
      int k;
      k = 0;
      while (attention_n !== 1'h0 && k < n) begin
         @(posedge clk);
         k++;
      end
      chk("line low", 0, attention_n);
   endtask

   task automatic whigh(input int n);
      int k;
      k = 0;
      while (attention_n !== 1'h1 && k < n) begin
         @(posedge clk);
         k++;
      end
      chk("line high", 1, attention_n);
      repeat (2) @(posedge clk);
   endtask

   task automatic nopulse(input int n);
      int f;
      f = i_sbil_host.n_low;
      repeat (n) @(posedge clk);
      chk("pulse count", f, i_sbil_host.n_low);
   endtask

   // lets the spacing gap run out so the next scenario starts idle
   task automatic settle;
      whigh(TO + MIN + 20);
      repeat (TO + 10) @(posedge clk);
   endtask

   // watchdog, well above the expected run length
   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      chk("idle line", 1, attention_n);
      rchk(OFS_MASK1, 8'hff);
      rchk(OFS_MASK2, 8'h07);
      rchk(OFS_MASK0, 8'h0f);
      rchk(OFS_IRQ0, 8'h00);
      rchk(OFS_IRQ1, 8'h00);
      rchk(OFS_IRQ2, 8'h00);
      rchk(3'h6, 8'h00);
      // wake pin event read at once: pulse still lasts the minimum width
      src.wake[2] <= 1'h1;
      wlow(6);
      rchk(OFS_IRQ0, 8'h08);
      src <= '0;
      whigh(MIN + 10);
      chk("min width", 1, i_sbil_host.last_low >= MIN && i_sbil_host.last_low <= MIN + 1);
      rchk(OFS_IRQ0, 8'h00);
      // event inside the gap, cleared by a read, still asserts later
      src.wake[0] <= 1'h1;
      repeat (10) @(posedge clk);
      chk("gap line", 1, attention_n);
      rchk(OFS_IRQ0, 8'h02);
      wlow(TO + 20);
      rchk(OFS_IRQ0, 8'h00);
      chk("gap width", 1, i_sbil_host.last_high >= TO);
      src <= '0;
      settle();
      // two events while low merge into one pulse
      src.wake[1] <= 1'h1;
      wlow(6);
      src.wake[3] <= 1'h1;
      repeat (20) @(posedge clk);
      rchk(OFS_IRQ0, 8'h14);
      whigh(MIN + 10);
      nopulse(TO + 20);
      src <= '0;
      // masked source is flagged but silent
      i_sbil_host.wr(OFS_MASK0, 8'h0b);
      src.wake[2] <= 1'h1;
      nopulse(20);
      rchk(OFS_IRQ0, 8'h08);
      i_sbil_host.wr(OFS_MASK0, 8'h0f);
      src <= '0;
      // no line activity outside normal and stop; summary bit follows flags
      mode <= MODE_SLEEP;
      src.fail[0] <= 1'h1;
      nopulse(20);
      rchk(OFS_IRQ0, 8'h01);
      rchk(OFS_IRQ2, 8'h01);
      rchk(OFS_IRQ0, 8'h00);
      src <= '0;
      i_sbil_host.wr(OFS_MASK1, 8'h00);
      mode <= MODE_RESTART;
      @(posedge clk);
      mode <= MODE_NORMAL;
      repeat (2) @(posedge clk);
      rchk(OFS_MASK1, 8'hff);
      // undervoltage hidden while the regulator is off
      reg_ctl.off_second <= 1'h1;
      src.fault[0] <= 1'h1;
      nopulse(20);
      // switch-on command, left unread until the time-out
      reg_ctl.off_second <= 1'h0;
      reg_ctl.on_second <= 1'h1;
      @(posedge clk);
      reg_ctl.on_second <= 1'h0;
      wlow(4);
      whigh(TO + 20);
      chk("timeout width", 1, i_sbil_host.last_low >= TO - 2 && i_sbil_host.last_low <= TO + 1);
      rchk(OFS_IRQ1, 8'h01);
      rchk(OFS_IRQ1, 8'h01);
      src.fault[0] <= 1'h0;
      wlow(TO + 30);
      rchk(OFS_IRQ1, 8'h01);
      rchk(OFS_IRQ1, 8'h00);
      settle();
      // overtemperature: rising edge only, flag mirrors state
      src.fault[2] <= 1'h1;
      wlow(6);
      rchk(OFS_IRQ1, 8'h04);
      whigh(TO + 20);
      src.fault[2] <= 1'h0;
      nopulse(TO + 30);
      rchk(OFS_IRQ1, 8'h00);
      finish_test();
   end
endmodule
